// ### pap_pkg.sv
// shared constants, types and the parity function of the address/data/parity port
// assumes one 50 MHz clock and a single-data-phase bus exchange
package pap_pkg;

	// ----------------------------------------------------------------
	// widths and storage
	// ----------------------------------------------------------------
	localparam int AD_W     = 32;
	localparam int CBE_W    = 4;
	localparam int LANE_W   = 8;
	localparam int WORDS    = 4;
	localparam int IDX_W    = 2;
	localparam int IDX_LSB  = 2;
	localparam int DEC_LSB  = 4;

	typedef logic [AD_W-1:0]  pap_word_t;
	typedef logic [CBE_W-1:0] pap_nib_t;
	typedef logic [IDX_W-1:0] pap_idx_t;

	// ----------------------------------------------------------------
	// bus commands carried on the command/byte-enable lanes
	// ----------------------------------------------------------------
	localparam pap_nib_t CMD_IO_RD  = 4'h2;
	localparam pap_nib_t CMD_IO_WR  = 4'h3;
	localparam pap_nib_t CMD_MEM_RD = 4'h6;
	localparam pap_nib_t CMD_MEM_WR = 4'h7;
	localparam int       CMD_WR_BIT = 0;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam pap_word_t WORD_RST  = 32'h0000_0000;
	localparam pap_nib_t  NIB_RST   = 4'h0;
	localparam pap_nib_t  NIB_IDLE  = 4'hF;
	localparam logic [7:0] LANE_RST = 8'h00;
	localparam logic [3:0] DEVSEL_WAIT = 4'h5;
	localparam logic [3:0] CNT_RST     = 4'h0;
	localparam logic [3:0] CNT_ONE     = 4'h1;

	// ----------------------------------------------------------------
	// state codes, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_ADDR = 4'h2,
		MS_DATA = 4'h4,
		MS_TURN = 4'h8
	} pap_mstate_t;

	typedef enum logic [4:0] {
		TS_IDLE  = 5'h01,
		TS_CLAIM = 5'h02,
		TS_XFER  = 5'h04,
		TS_TURN  = 5'h08,
		TS_BUSY  = 5'h10
	} pap_tstate_t;

	// even parity bit over address/data and command/byte-enable lanes
	function automatic logic pap_even_par(input pap_word_t ad, input pap_nib_t cbe);
		return ^{ad, cbe};
	endfunction

endpackage

// ### pap_bus_if.sv
// shared bus lines between initiator and target ends
// each end drives value plus enable; the wire level is resolved here, idle control lines pull high
`timescale 1ns/100ps
interface pap_bus_if;
	import pap_pkg::*;

	// ----------------------------------------------------------------
	// per-end drives
	// ----------------------------------------------------------------
	pap_word_t mAd;
	logic      mAdOe;
	pap_nib_t  mCbe;
	logic      mCbeOe;
	logic      mPar;
	logic      mParOe;
	logic      mFrameN;
	logic      mFrameOe;
	logic      mIrdyN;
	logic      mIrdyOe;
	pap_word_t tAd;
	logic      tAdOe;
	logic      tPar;
	logic      tParOe;
	logic      tTrdyN;
	logic      tTrdyOe;
	logic      tDevselN;
	logic      tDevselOe;

	// ----------------------------------------------------------------
	// resolved levels
	// ----------------------------------------------------------------
	pap_word_t ad;
	pap_nib_t  cbe;
	logic      par;
	logic      frameN;
	logic      irdyN;
	logic      trdyN;
	logic      devselN;

	// undriven lines read as pulled up, data lanes and parity as zero
	assign ad      = mAdOe ? mAd : (tAdOe ? tAd : WORD_RST);
	assign cbe     = mCbeOe ? mCbe : NIB_IDLE;
	assign par     = mParOe ? mPar : (tParOe ? tPar : 1'b0);
	assign frameN  = mFrameOe ? mFrameN : 1'b1;
	assign irdyN   = mIrdyOe ? mIrdyN : 1'b1;
	assign trdyN   = tTrdyOe ? tTrdyN : 1'b1;
	assign devselN = tDevselOe ? tDevselN : 1'b1;

	modport initiator (
		output mAd, mAdOe, mCbe, mCbeOe, mPar, mParOe, mFrameN, mFrameOe, mIrdyN, mIrdyOe,
		input  ad, cbe, par, frameN, irdyN, trdyN, devselN
	);

	modport target (
		output tAd, tAdOe, tPar, tParOe, tTrdyN, tTrdyOe, tDevselN, tDevselOe,
		input  ad, cbe, par, frameN, irdyN, trdyN, devselN
	);
endinterface

// ### pap_initiator.sv
// initiator end: one address phase then one data phase per request
// assumes the bus lines come from logic on sys_clk, so no synchronisers
`timescale 1ns/100ps
module pap_initiator
	import pap_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	pap_bus_if.initiator    bus,
	input  wire logic       reqValid,
	input  wire pap_nib_t   reqCmd,
	input  wire pap_word_t  reqAddr,
	input  wire pap_word_t  reqData,
	input  wire pap_nib_t   reqBeN,
	output logic            reqReady,
	output logic            doneStrobe,
	output pap_word_t       rdData,
	output logic            masterAbort,
	output logic            dataParErr
);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	pap_mstate_t state_reg;
	pap_mstate_t stateNext;
	logic        idleSeen_reg;
	logic [3:0]  waitCnt_reg;
	pap_word_t   data_reg;
	pap_nib_t    be_reg;
	pap_nib_t    cmd_reg;
	logic        chkRd_reg;
	pap_nib_t    rdBe_reg;

	wire busFree  = bus.frameN & bus.irdyN;
	// lines seen released for a clock before we take them
	wire start    = (state_reg == MS_IDLE) & reqValid & busFree & idleSeen_reg;
	wire isWrite  = cmd_reg[CMD_WR_BIT];
	wire complete = (state_reg == MS_DATA) & ~bus.irdyN & ~bus.trdyN;
	wire abort    = (state_reg == MS_DATA) & bus.devselN & (waitCnt_reg == DEVSEL_WAIT);

	// next state decode
	assign stateNext = (state_reg == MS_IDLE) ? (start ? MS_ADDR : MS_IDLE) :
		(state_reg == MS_ADDR) ? MS_DATA :
		(state_reg == MS_DATA) ? ((complete | abort) ? MS_TURN : MS_DATA) : MS_IDLE;

	// ----------------------------------------------------------------
	// drive values, all taken from the next state so outputs are flops
	// ----------------------------------------------------------------
	wire nAddr = (stateNext == MS_ADDR);
	wire nData = (stateNext == MS_DATA);
	wire nTurn = (stateNext == MS_TURN);
	wire frameOeNext = nAddr | nData;
	wire frameNNext  = ~nAddr;
	wire irdyOeNext  = nData | nTurn;
	wire irdyNNext   = ~nData;
	wire cbeOeNext   = nAddr | nData;
	wire pap_nib_t cbeNext  = nAddr ? reqCmd : be_reg;
	wire pap_word_t adNext  = nAddr ? reqAddr : data_reg;
	// write data only; on reads the lanes turn round to the target
	wire adOeNext    = nAddr | (nData & isWrite);

	// sequencer and request capture
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg    <= MS_IDLE;
			idleSeen_reg <= 1'b0;
			waitCnt_reg  <= CNT_RST;
			data_reg     <= WORD_RST;
			be_reg       <= NIB_IDLE;
			cmd_reg      <= NIB_RST;
		end else begin
			state_reg    <= stateNext;
			idleSeen_reg <= busFree;
			waitCnt_reg  <= (state_reg == MS_DATA) ? waitCnt_reg + CNT_ONE : CNT_RST;
			if (start) begin
				data_reg <= reqData;
				be_reg   <= reqBeN;
				cmd_reg  <= reqCmd;
			end
		end
	end

	// bus drive registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bus.mFrameOe <= 1'b0;
			bus.mFrameN  <= 1'b1;
			bus.mIrdyOe  <= 1'b0;
			bus.mIrdyN   <= 1'b1;
			bus.mCbeOe   <= 1'b0;
			bus.mCbe     <= NIB_IDLE;
			bus.mAdOe    <= 1'b0;
			bus.mAd      <= WORD_RST;
			bus.mParOe   <= 1'b0;
			bus.mPar     <= 1'b0;
		end else begin
			bus.mFrameOe <= frameOeNext;
			bus.mFrameN  <= frameNNext;
			bus.mIrdyOe  <= irdyOeNext;
			bus.mIrdyN   <= irdyNNext;
			bus.mCbeOe   <= cbeOeNext;
			bus.mCbe     <= cbeNext;
			bus.mAdOe    <= adOeNext;
			bus.mAd      <= adNext;
			// parity follows the lanes it covers by one clock, held a clock past completion
			bus.mParOe   <= bus.mAdOe;
			bus.mPar     <= pap_even_par(bus.mAd, bus.mCbe);
		end
	end

	// ----------------------------------------------------------------
	// user answers and read parity check
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reqReady    <= 1'b0;
			doneStrobe  <= 1'b0;
			masterAbort <= 1'b0;
			rdData      <= WORD_RST;
			rdBe_reg    <= NIB_IDLE;
			chkRd_reg   <= 1'b0;
			dataParErr  <= 1'b0;
		end else begin
			reqReady    <= (stateNext == MS_IDLE);
			doneStrobe  <= complete | abort;
			masterAbort <= abort;
			chkRd_reg   <= complete & ~isWrite;
			if (complete & ~isWrite) begin
				rdData   <= bus.ad;
				rdBe_reg <= bus.cbe;
			end
			// target parity arrives the clock after completion
			dataParErr  <= chkRd_reg & (pap_even_par(rdData, rdBe_reg) != bus.par);
		end
	end

endmodule

// ### pap_target.sv
// target end: claims a small window of four words and answers one data phase
// assumes the bus lines come from logic on sys_clk, so no synchronisers are fitted
`timescale 1ns/100ps

module pap_target
	import pap_pkg::*;
#(
	parameter pap_word_t BASE_ADDR = 32'h0000_1000
)
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	pap_bus_if.target       bus,
	output logic            wrStrobe,
	output pap_idx_t        wrIndex,
	output pap_word_t       wrData,
	output pap_nib_t        wrLaneEn,
	output logic            rdStrobe,
	output logic            addrParErr,
	output logic            dataParErr
);

	// ----------------------------------------------------------------
	// address phase capture and decode
	// ----------------------------------------------------------------
	pap_tstate_t state_reg;
	pap_tstate_t stateNext;
	logic        frameHigh_reg;
	pap_word_t   addr_reg;
	pap_nib_t    cmd_reg;
	logic        chkAddr_reg;
	logic        chkData_reg;
	pap_word_t   wdCap_reg;
	pap_nib_t    beCap_reg;

	// a falling frame while idle marks the one address phase
	wire addrPhase = (state_reg == TS_IDLE) & ~bus.frameN & frameHigh_reg;

	// memory and I/O reads/writes are claimed; others are let pass
	wire cmdOk = (bus.cbe == CMD_MEM_RD) | (bus.cbe == CMD_MEM_WR) |
		(bus.cbe == CMD_IO_RD) | (bus.cbe == CMD_IO_WR);
	wire hit   = addrPhase & cmdOk &
		(bus.ad[AD_W-1:DEC_LSB] == BASE_ADDR[AD_W-1:DEC_LSB]);

	// dword select; for I/O the low two address bits name a byte and do
	// not move the word, the byte enables pick the lanes
	wire pap_idx_t idx = addr_reg[IDX_LSB +: IDX_W];
	wire isWrite  = cmd_reg[CMD_WR_BIT];
	wire complete = (state_reg == TS_XFER) & ~bus.irdyN & ~bus.trdyN;
	wire otherEnd = bus.frameN & bus.irdyN;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	assign stateNext = (state_reg == TS_IDLE)  ? (hit ? TS_CLAIM : (addrPhase ? TS_BUSY : TS_IDLE)) :
		(state_reg == TS_CLAIM) ? TS_XFER :
		(state_reg == TS_XFER)  ? (complete ? TS_TURN : TS_XFER) :
		(state_reg == TS_TURN)  ? TS_IDLE :
		(otherEnd ? TS_IDLE : TS_BUSY);

	// sequencer and address capture
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg     <= TS_IDLE;
			frameHigh_reg <= 1'b0;
			addr_reg      <= WORD_RST;
			cmd_reg       <= NIB_RST;
		end else begin
			state_reg     <= stateNext;
			frameHigh_reg <= bus.frameN;
			if (addrPhase) begin
				addr_reg <= bus.ad;
				cmd_reg  <= bus.cbe;
			end
		end
	end

	// ----------------------------------------------------------------
	// word store, one flop array per byte lane
	// ----------------------------------------------------------------
	pap_word_t rdWord;
	wire laneWrGo = complete & isWrite;

	// lane n sits on bits 8n+7..8n, lane 0 least significant
	for (genvar ln = 0; ln < CBE_W; ln++) begin : g_lane
		logic [LANE_W-1:0] laneMem_reg [WORDS];
		// only enabled lanes carry data worth keeping
		wire laneWr = laneWrGo & ~bus.cbe[ln];
		assign rdWord[ln*LANE_W +: LANE_W] = laneMem_reg[idx];
		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				for (int w = 0; w < WORDS; w++) begin
					laneMem_reg[w] <= LANE_RST;
				end
			end else if (laneWr) begin
				laneMem_reg[idx] <= bus.ad[ln*LANE_W +: LANE_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// bus drive values from the next state
	// ----------------------------------------------------------------
	wire nClaim = (stateNext == TS_CLAIM);
	wire nXfer  = (stateNext == TS_XFER);
	wire nTurn  = (stateNext == TS_TURN);
	// the claim clock drives ready high and select low first, so the address
	// phase owner has had its clock of release
	wire ownNext    = nClaim | nXfer | nTurn;
	wire devselNNxt = ~(nClaim | nXfer);
	// turn clock drives ready and select high before floating
	wire trdyNNxt   = ~nXfer;
	// read data only; CLAIM is the turn-round clock for the lanes
	wire adOeNext   = nXfer & ~isWrite;

	// bus drive registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bus.tDevselOe <= 1'b0;
			bus.tDevselN  <= 1'b1;
			bus.tTrdyOe   <= 1'b0;
			bus.tTrdyN    <= 1'b1;
			bus.tAdOe     <= 1'b0;
			bus.tAd       <= WORD_RST;
			bus.tParOe    <= 1'b0;
			bus.tPar      <= 1'b0;
		end else begin
			bus.tDevselOe <= ownNext;
			bus.tDevselN  <= devselNNxt;
			bus.tTrdyOe   <= ownNext;
			bus.tTrdyN    <= trdyNNxt;
			bus.tAdOe     <= adOeNext;
			bus.tAd       <= rdWord;
			// parity trails the driven lanes by a clock and so stays one
			// clock past completion; byte enables come from the initiator
			bus.tParOe    <= bus.tAdOe;
			bus.tPar      <= pap_even_par(bus.tAd, bus.cbe);
		end
	end

	// ----------------------------------------------------------------
	// parity checks on what we receive
	// ----------------------------------------------------------------
	// every address phase is checked, claimed or not, since a bad
	// address could have hidden a hit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			chkAddr_reg <= 1'b0;
			chkData_reg <= 1'b0;
			wdCap_reg   <= WORD_RST;
			beCap_reg   <= NIB_IDLE;
			addrParErr  <= 1'b0;
			dataParErr  <= 1'b0;
		end else begin
			chkAddr_reg <= addrPhase;
			chkData_reg <= laneWrGo;
			if (laneWrGo) begin
				wdCap_reg <= bus.ad;
				beCap_reg <= bus.cbe;
			end
			addrParErr  <= chkAddr_reg & (pap_even_par(addr_reg, cmd_reg) != bus.par);
			dataParErr  <= chkData_reg & (pap_even_par(wdCap_reg, beCap_reg) != bus.par);
		end
	end

	// ----------------------------------------------------------------
	// user-side event reporting
	// ----------------------------------------------------------------
	// write report shows raw lane data; disabled lanes are not stored
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrStrobe <= 1'b0;
			wrIndex  <= '0;
			wrData   <= WORD_RST;
			wrLaneEn <= NIB_RST;
			rdStrobe <= 1'b0;
		end else begin
			wrStrobe <= laneWrGo;
			rdStrobe <= complete & ~isWrite;
			if (complete) begin
				wrIndex  <= idx;
				wrData   <= bus.ad;
				wrLaneEn <= ~bus.cbe;
			end
		end
	end

endmodule

// ### pap_bus_properties.sv
// concurrent checks on the shared lines between the initiator and target ends
// assumes the bench instantiates it once beside pap_bus_if, wired by name
`timescale 1ns/100ps
module pap_bus_properties
	import pap_pkg::*;
(
	input wire logic      sys_clk,
	input wire logic      rst_n,
	input wire pap_word_t ad,
	input wire pap_nib_t  cbe,
	input wire logic      par,
	input wire logic      frameN,
	input wire logic      irdyN,
	input wire logic      trdyN,
	input wire logic      devselN,
	input wire logic      mAdOe,
	input wire logic      mParOe,
	input wire logic      mFrameN,
	input wire logic      mFrameOe,
	input wire logic      mIrdyN,
	input wire logic      mIrdyOe,
	input wire logic      tAdOe,
	input wire logic      tParOe,
	input wire logic      tTrdyN,
	input wire logic      tTrdyOe
);
	// one clock domain, so one default clock and one disable
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// ownership and hand-over of sustained lines
	// ----------------------------------------------------------------
	AST_IRDY_RELEASE: assert property (mIrdyOe && !mIrdyN |=> mIrdyOe)
		else $error("initiator ready floated while low");
	AST_TRDY_RELEASE: assert property (tTrdyOe && !tTrdyN |=> tTrdyOe)
		else $error("target ready floated while low");
	AST_FRAME_RELEASE: assert property (mFrameOe && !mFrameN |=> mFrameOe)
		else $error("frame floated while low");
	AST_AD_TURNAROUND: assert property ($rose(tAdOe) |-> !mAdOe && !$past(mAdOe))
		else $error("target drove data lanes without a turnaround clock");
	AST_ONE_OWNER: assert property (!(mAdOe && tAdOe) && !(mParOe && tParOe))
		else $error("two ends drive the same lines");

	// ----------------------------------------------------------------
	// phases and parity timing
	// ----------------------------------------------------------------
	AST_ADDR_PAR: assert property ($fell(frameN) |=> mParOe && (par == ^{$past(ad), $past(cbe)}))
		else $error("address parity wrong or late");
	AST_WR_PAR: assert property (!irdyN && mAdOe |=> mParOe && (par == ^{$past(ad), $past(cbe)}))
		else $error("write data parity wrong or late");
	AST_RD_PAR: assert property (!trdyN && tAdOe |=> tParOe && !mParOe && (par == ^{$past(ad), $past(cbe)}))
		else $error("read data parity wrong or late");
	AST_PAR_HELD: assert property (!irdyN && !trdyN && mAdOe |=> $stable(par))
		else $error("parity changed right after completion");
	// a master abort ends the phase with ready raised, so only a phase still open must keep its enables
	AST_BE_STEADY: assert property (!irdyN && trdyN ##1 !irdyN |-> $stable(cbe))
		else $error("byte enables moved inside a data phase");
	AST_FRAME_LAST: assert property ($fell(frameN) |=> frameN && !irdyN)
		else $error("single data phase not marked by frame release");
	AST_TRDY_AFTER_CLAIM: assert property ($fell(devselN) |=> !trdyN && !irdyN)
		else $error("data phase did not complete a clock after claim");
endmodule

// ### testbench.sv
// self-checking bench: initiator and target ends joined across pap_bus_if
// assumes the package, interface, both ends and the checker are compiled first
`timescale 1ns/100ps
module testbench;
	import pap_pkg::*;

	typedef struct {logic abort; logic rd; pap_word_t data; pap_word_t mask;} pap_tb_note_t;
	typedef struct {pap_idx_t idx; pap_word_t data; pap_nib_t lanes;} pap_tb_wnote_t;
	localparam pap_word_t BASE     = 32'h0000_2340;
	localparam int        LIMIT    = 20000;
	localparam pap_nib_t  CMDS [4] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR};

	logic          sys_clk     = 1'b0;
	logic          rst_n       = 1'b0;
	logic          reqValid    = 1'b0;
	pap_nib_t      reqCmd      = NIB_RST;
	pap_word_t     reqAddr     = WORD_RST;
	pap_word_t     reqData     = WORD_RST;
	pap_nib_t      reqBeN      = NIB_RST;
	logic          reqReady;
	logic          doneStrobe;
	logic          masterAbort;
	logic          iParErr;
	logic          wrStrobe;
	logic          rdStrobe;
	logic          addrParErr;
	logic          tParErr;
	pap_word_t     rdData;
	pap_word_t     wrData;
	pap_idx_t      wrIndex;
	pap_nib_t      wrLaneEn;
	pap_word_t     mem [WORDS] = '{default: WORD_RST};
	pap_tb_note_t  doneQ [$];
	pap_tb_wnote_t wrQ [$];
	pap_tb_note_t  n;
	pap_tb_wnote_t w;
	int            miscompares = 0;
	int            comparisons = 0;
	int            cycles      = 0;

	// ----------------------------------------------------------------
	// both ends, the shared lines and the checker
	// ----------------------------------------------------------------
	pap_bus_if bus ();
	pap_initiator pap_initiator_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.initiator), .reqValid(reqValid),
		.reqCmd(reqCmd), .reqAddr(reqAddr), .reqData(reqData), .reqBeN(reqBeN), .reqReady(reqReady),
		.doneStrobe(doneStrobe), .rdData(rdData), .masterAbort(masterAbort), .dataParErr(iParErr));
	pap_target #(.BASE_ADDR(BASE)) pap_target_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.target),
		.wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData), .wrLaneEn(wrLaneEn), .rdStrobe(rdStrobe),
		.addrParErr(addrParErr), .dataParErr(tParErr));
	pap_bus_properties pap_bus_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .ad(bus.ad), .cbe(bus.cbe),
		.par(bus.par), .frameN(bus.frameN), .irdyN(bus.irdyN), .trdyN(bus.trdyN), .devselN(bus.devselN),
		.mAdOe(bus.mAdOe), .mParOe(bus.mParOe), .mFrameN(bus.mFrameN), .mFrameOe(bus.mFrameOe),
		.mIrdyN(bus.mIrdyN), .mIrdyOe(bus.mIrdyOe), .tAdOe(bus.tAdOe), .tParOe(bus.tParOe),
		.tTrdyN(bus.tTrdyN), .tTrdyOe(bus.tTrdyOe));

	// free-running 50 MHz clock
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// comparison, verdict and one transfer
	// ----------------------------------------------------------------
	task automatic check(input pap_word_t seen, input pap_word_t want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// notes the outcome first, then holds the request until the initiator leaves idle
	task automatic xfer(input pap_nib_t cmd, input pap_word_t addr, input pap_word_t data, input pap_nib_t beN);
		logic      hit;
		pap_idx_t  idx;
		pap_word_t mask;
		hit  = (cmd inside {CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR}) && (addr[31:DEC_LSB] == BASE[31:DEC_LSB]);
		idx  = addr[IDX_LSB +: IDX_W];
		mask = {{8{!beN[3]}}, {8{!beN[2]}}, {8{!beN[1]}}, {8{!beN[0]}}};
		doneQ.push_back('{!hit, hit && !cmd[CMD_WR_BIT], mem[idx] & mask, mask});
		if (hit && cmd[CMD_WR_BIT]) begin
			wrQ.push_back('{idx, data, ~beN});
			mem[idx] = (mem[idx] & ~mask) | (data & mask);
		end
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqCmd   <= cmd;
		reqAddr  <= addr;
		reqData  <= data;
		reqBeN   <= beN;
		do @(posedge sys_clk); while (reqReady !== 1'b0);
		reqValid <= 1'b0;
		do @(posedge sys_clk); while (reqReady !== 1'b1);
	endtask

	// ----------------------------------------------------------------
	// watcher: takes the oldest note whenever a result shows
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			complete_run();
		end else if (rst_n === 1'b1) begin
			check({29'h0, addrParErr, tParErr, iParErr}, WORD_RST);
			// the target's read report must line up with a claimed read ending
			check({31'h0, rdStrobe}, {31'h0, doneStrobe === 1'b1 && doneQ.size() != 0 && doneQ[0].rd});
			if (doneStrobe === 1'b1) begin
				check(pap_word_t'(doneQ.size() != 0), 32'h0000_0001);
				if (doneQ.size() != 0) begin
					n = doneQ.pop_front();
					check({31'h0, masterAbort}, {31'h0, n.abort});
					if (n.rd) check(rdData & n.mask, n.data);
				end
			end
			if (wrStrobe === 1'b1) begin
				check(pap_word_t'(wrQ.size() != 0), 32'h0000_0001);
				if (wrQ.size() != 0) begin
					w = wrQ.pop_front();
					check({30'h0, wrIndex}, {30'h0, w.idx});
					check(wrData, w.data);
					check({28'h0, wrLaneEn}, {28'h0, w.lanes});
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		pap_nib_t cmd;
		void'($urandom(32'hE969));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		// reset contents read back as zero
		for (int i = 0; i < WORDS; i++) xfer(CMD_MEM_RD, {BASE[31:DEC_LSB], pap_idx_t'(i), 2'b00}, WORD_RST, NIB_RST);
		// random mix, first ones writes; I/O uses random byte offsets 0 to 3
		for (int i = 0; i < 40; i++) begin
			cmd = CMDS[(i < 4) ? 3 : $urandom_range(3)];
			xfer(cmd, {BASE[31:DEC_LSB], pap_idx_t'($urandom_range(3)), cmd[2] ? 2'b00 : 2'($urandom_range(3))},
				$urandom, pap_nib_t'($urandom));
		end
		// outside the window and an unclaimed command end in abort
		foreach (CMDS[k]) xfer(CMDS[k], BASE ^ 32'h0001_0000, $urandom, NIB_RST);
		xfer(4'hA, BASE, WORD_RST, NIB_RST);
		// read everything back with all lanes on
		for (int i = 0; i < WORDS; i++) xfer(CMD_IO_RD, {BASE[31:DEC_LSB], pap_idx_t'(i), 2'b11}, WORD_RST, NIB_RST);
		repeat (10) @(posedge sys_clk);
		check(pap_word_t'(doneQ.size() + wrQ.size()), WORD_RST);
		complete_run();
	end
endmodule
